// *** logic/crf_rx_filter.sv ***
/*
 receive buffer layout, acceptance filter and receive queue of a can unit.
 assumes the protocol engine hands one decoded frame per rx_valid pulse,
 synchronous to mclk, and software uses classic wishbone.
*/
`timescale 1ns/10ps

module crf_rx_filter
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   // frames from the protocol engine
   input  wire logic                   rx_valid,
   input  wire crf_pkg::crf_frame_type rx_frame,
   // wishbone slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [9:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   // status
   output logic                        rx_dropped,
   output logic                        rx_overrun
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0]             mode_reg;
   logic                   ext_mode;
   logic [7:0]             code   [4];
   logic [7:0]             mask   [4];
   crf_pkg::crf_frame_type rxq    [crf_pkg::RXQ_DEPTH];
   logic [crf_pkg::RXQ_AW-1:0] rd_ptr;
   logic [crf_pkg::RXQ_AW-1:0] wr_ptr;
   logic [crf_pkg::RXQ_CW-1:0] count;

   logic       in_reset_mode;
   logic       dual_mode;
   logic       wb_req;
   logic       wr_stb;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic       accept;
   logic       release_msg;
   logic       q_full;

   // ---------------------------------------------------------------
   // bus decode and queue status
   // ---------------------------------------------------------------
   assign in_reset_mode = mode_reg[crf_pkg::MODE_RESET_BIT];
   assign dual_mode     = mode_reg[crf_pkg::MODE_DUAL_BIT];
   assign wb_req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_stb        = wb_req & wb_we_i & wb_sel_i[0];
   assign idx           = wb_adr_i[9:2];
   assign wbyte         = wb_dat_i[7:0];
   assign q_full        = (count == 5'(crf_pkg::RXQ_DEPTH));
   assign release_msg   = wr_stb & (idx == crf_pkg::IDX_RX_RELEASE) & (count != '0);

   // ---------------------------------------------------------------
   // acceptance filter
   // ---------------------------------------------------------------
   // a compare vector, its code and its mask; mask 1 forces agreement
   function automatic logic hit(input logic [31:0] v, input logic [31:0] c,
                                input logic [31:0] m, input logic [31:0] used);
      hit = &(~used | m | ~(v ^ c));
   endfunction

   // ---------------------------------------------------------------
   // compared positions per filter; a clear bit is never compared,
   // so unused code bits can not block a frame
   // ---------------------------------------------------------------
   localparam logic [31:0] USE_SB_FULL   = 32'hfff0ffff;
   localparam logic [31:0] USE_SB_COMPAT = 32'hff000000;
   localparam logic [31:0] USE_SE        = 32'hfffffffc;
   localparam logic [31:0] USE_DB1       = 32'hffff000f;
   localparam logic [31:0] USE_DB2       = 32'h0000fff0;
   localparam logic [31:0] USE_DE1       = 32'hffff0000;
   localparam logic [31:0] USE_DE2       = 32'h0000ffff;

   logic [31:0] code_w;
   logic [31:0] mask_w;
   logic [31:0] vec_sb;
   logic [31:0] vec_se;
   logic [31:0] vec_db;
   logic [31:0] vec_de;
   logic [31:0] use_sb;
   logic [31:0] use_db1;
   logic [31:0] use_db2;
   logic [31:0] use_de1;
   logic [31:0] use_de2;
   logic        f1;
   logic        f2;

   // ---------------------------------------------------------------
   // compare vectors, laid out like the four code bytes
   // ---------------------------------------------------------------
   always_comb
   begin
      code_w  = {code[0], code[1], code[2], code[3]};
      mask_w  = {mask[0], mask[1], mask[2], mask[3]};
      // single base: id[10:0], rtr, 4 unused, data0, data1
      vec_sb  = {rx_frame.ident_bits[10:0], rx_frame.rtr, 4'h0,
                 rx_frame.data[63:48]};
      use_sb  = ext_mode ? USE_SB_FULL : USE_SB_COMPAT;
      // single extended: id[28:0], rtr, 2 unused
      vec_se  = {rx_frame.ident_bits, rx_frame.rtr, 2'h0};
      // dual base: f1 id+rtr+hi nibble in bytes 0/1, lo nibble in byte 3
      vec_db  = {rx_frame.ident_bits[10:0], rx_frame.rtr, rx_frame.data[63:60],
                 rx_frame.ident_bits[10:0], rx_frame.rtr, rx_frame.data[59:56]};
      use_db1 = USE_DB1;
      use_db2 = USE_DB2;
      vec_de  = {rx_frame.ident_bits[28:13], rx_frame.ident_bits[28:13]};
      use_de1 = USE_DE1;
      use_de2 = USE_DE2;
   end

   // ---------------------------------------------------------------
   // filter decision
   // ---------------------------------------------------------------
   always_comb
   begin
      f1      = 1'b0;
      f2      = 1'b0;
      if (!dual_mode)
      begin
         if (rx_frame.format_flag)
            f1 = hit(vec_se, code_w, mask_w, USE_SE);
         else
            f1 = hit(vec_sb, code_w, mask_w, use_sb);
      end
      else if (rx_frame.format_flag)
      begin
         f1 = hit(vec_de, code_w, mask_w, use_de1);
         f2 = hit(vec_de, code_w, mask_w, use_de2);
      end
      else
      begin
         f1 = hit(vec_db, code_w, mask_w, use_db1);
         f2 = hit(vec_db, code_w, mask_w, use_db2);
      end
      accept = f1 | f2;
   end

   // ---------------------------------------------------------------
   // mode and compat registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         mode_reg <= crf_pkg::MODE_RST_VAL;
      else if (wr_stb && idx == crf_pkg::IDX_MODE)
         mode_reg <= wbyte;
   end

   // compat: base frames in single mode use code0 only
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         ext_mode <= 1'b0;
      else if (wr_stb && idx == crf_pkg::IDX_CLKDIV)
         ext_mode <= wbyte[crf_pkg::CLKDIV_EXT_BIT];
   end

   // ---------------------------------------------------------------
   // code and mask bytes, writable only in reset mode
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_filt
         always_ff @(posedge mclk)
         begin
            if (sys_rst)
            begin
               code[g] <= (g == 0) ? crf_pkg::CODE0_RST_VAL : crf_pkg::OTHER_RST_VAL;
               mask[g] <= (g == 0) ? crf_pkg::MASK0_RST_VAL : crf_pkg::OTHER_RST_VAL;
            end
            else if (wr_stb && in_reset_mode)
            begin
               if (idx == crf_pkg::IDX_CODE0 + 8'(g))
                  code[g] <= wbyte;
               if (idx == crf_pkg::IDX_MASK0 + 8'(g))
                  mask[g] <= wbyte;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // receive queue; frames are dropped in reset mode or when full
   // ---------------------------------------------------------------
   logic push;
   assign push = rx_valid & accept & ~in_reset_mode & ~q_full;

   always_ff @(posedge mclk)
   begin
      if (push)
         rxq[wr_ptr] <= rx_frame;
   end

   // pointers and count clear together, so reset mode flushes the queue
   always_ff @(posedge mclk)
   begin
      if (sys_rst || in_reset_mode)
         wr_ptr <= '0;
      else if (push)
         wr_ptr <= wr_ptr + 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst || in_reset_mode)
         rd_ptr <= '0;
      else if (release_msg)
         rd_ptr <= rd_ptr + 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst || in_reset_mode)
         count <= '0;
      else
         count <= count + 5'(push) - 5'(release_msg);
   end

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   // sticky until reset mode; a new event wins over the clear
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         rx_dropped <= 1'b0;
      else if (rx_valid && !accept)
         rx_dropped <= 1'b1;
      else if (in_reset_mode)
         rx_dropped <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         rx_overrun <= 1'b0;
      else if (rx_valid && accept && q_full)
         rx_overrun <= 1'b1;
      else if (in_reset_mode)
         rx_overrun <= 1'b0;
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   crf_pkg::crf_frame_type hd;
   logic [7:0]             rbyte;
   logic [7:0]             reg_byte;
   logic                   reg_hit;
   logic [7:0]             frame_byte;
   logic [7:0]             off;
   logic [7:0]             dbyte [8];

   assign hd = rxq[rd_ptr];

   // ---------------------------------------------------------------
   // data bytes of the head frame, byte 0 in the top bits
   // ---------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < 8; b++)
      begin : g_dbyte
         assign dbyte[b] = hd.data[63 - 8 * b -: 8];
      end
   endgenerate

   // ---------------------------------------------------------------
   // register side; filter bytes shadow the frame only in reset mode
   // ---------------------------------------------------------------
   always_comb
   begin
      reg_hit  = 1'b1;
      reg_byte = 8'h00;
      if (idx == crf_pkg::IDX_MODE)
         reg_byte = mode_reg;
      else if (idx == crf_pkg::IDX_CLKDIV)
         reg_byte = {ext_mode, 7'h00};
      else if (idx == crf_pkg::IDX_RX_COUNT)
         reg_byte = {3'h0, count};
      else if (idx >= crf_pkg::IDX_CODE0 && idx <= crf_pkg::IDX_MASK3 && in_reset_mode)
         reg_byte = (idx < crf_pkg::IDX_MASK0) ? code[idx[1:0]] : mask[idx[1:0]];
      else
         reg_hit = 1'b0;
   end

   // ---------------------------------------------------------------
   // frame side; an empty queue or reset mode reads zero
   // ---------------------------------------------------------------
   always_comb
   begin
      frame_byte = 8'h00;
      off        = 8'h00;
      if (in_reset_mode || count == '0)
         frame_byte = 8'h00;
      else if (idx == crf_pkg::IDX_RX_INFO)
         frame_byte = {hd.format_flag, hd.rtr, 2'h0, hd.length_code};
      else if (idx == crf_pkg::IDX_ID1)
         frame_byte = hd.format_flag ? hd.ident_bits[28:21] : hd.ident_bits[10:3];
      else if (idx == crf_pkg::IDX_ID2)
         frame_byte = hd.format_flag ? hd.ident_bits[20:13] : {hd.ident_bits[2:0], hd.rtr, 4'h0};
      else if (hd.format_flag && idx == crf_pkg::IDX_ID3)
         frame_byte = hd.ident_bits[12:5];
      else if (hd.format_flag && idx == crf_pkg::IDX_ID4)
         frame_byte = {hd.ident_bits[4:0], hd.rtr, 2'h0};
      else if (!hd.format_flag && idx >= crf_pkg::IDX_BASE_DATA0 && idx <= crf_pkg::IDX_BASE_DATA7)
      begin
         off        = idx - crf_pkg::IDX_BASE_DATA0;
         frame_byte = dbyte[off[2:0]];
      end
      else if (hd.format_flag && idx >= crf_pkg::IDX_EXT_DATA0 && idx <= crf_pkg::IDX_EXT_DATA7)
      begin
         off        = idx - crf_pkg::IDX_EXT_DATA0;
         frame_byte = dbyte[off[2:0]];
      end
   end

   assign rbyte = reg_hit ? reg_byte : frame_byte;

   // ---------------------------------------------------------------
   // wishbone answer: one cycle after the strobe, unmapped reads zero
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req;
   end

   // only reads carry data; writes and idle cycles show zero
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         wb_dat_o <= '0;
      else if (wb_req && !wb_we_i)
         wb_dat_o <= {24'h0, rbyte};
      else
         wb_dat_o <= '0;
   end

endmodule

// *** logic/crf_pkg.sv ***
/*
 package for the receive buffer and acceptance filter: register offsets,
 field positions, reset values, and the frame carrier struct.
 assumes a classic wishbone slave with 32-bit data, one register per word.
*/
package crf_pkg;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_MODE        = 8'h00;
   localparam logic [7:0] IDX_RX_INFO     = 8'h10;
   localparam logic [7:0] IDX_ID1         = 8'h11;
   localparam logic [7:0] IDX_ID2         = 8'h12;
   localparam logic [7:0] IDX_ID3         = 8'h13;
   localparam logic [7:0] IDX_ID4         = 8'h14;
   localparam logic [7:0] IDX_CODE0       = 8'h10;
   localparam logic [7:0] IDX_MASK0       = 8'h14;
   localparam logic [7:0] IDX_MASK3       = 8'h17;
   localparam logic [7:0] IDX_BASE_DATA0  = 8'h13;
   localparam logic [7:0] IDX_BASE_DATA7  = 8'h1a;
   localparam logic [7:0] IDX_EXT_DATA0   = 8'h15;
   localparam logic [7:0] IDX_EXT_DATA7   = 8'h1c;
   localparam logic [7:0] IDX_RX_COUNT    = 8'h1d;
   localparam logic [7:0] IDX_CLKDIV      = 8'h1f;
   localparam logic [7:0] IDX_RX_RELEASE  = 8'h20;

   // ---------------------------------------------------------------
   // mode register bits, compat bit, reset values
   // ---------------------------------------------------------------
   localparam int         MODE_RESET_BIT  = 0;
   localparam int         MODE_DUAL_BIT   = 3;
   localparam int         CLKDIV_EXT_BIT  = 7;
   localparam logic [7:0] MODE_RST_VAL    = 8'h01;
   localparam logic [7:0] CODE0_RST_VAL   = 8'h51;
   localparam logic [7:0] MASK0_RST_VAL   = 8'hff;
   localparam logic [7:0] OTHER_RST_VAL   = 8'h00;

   // ---------------------------------------------------------------
   // received frame carrier and receive queue
   // ---------------------------------------------------------------
   localparam int         RXQ_DEPTH       = 8;
   localparam int         RXQ_AW          = 3;
   localparam int         RXQ_CW          = 5;

   typedef struct packed {
      logic        format_flag;
      logic        rtr;
      logic [3:0]  length_code;
      logic [28:0] ident_bits;
      logic [63:0] data;
   } crf_frame_type;

endpackage

// *** sim/crf_eng_model.sv ***
/*
 stand-in for the protocol engine: hands decoded frames to the filter.
 assumes the bench calls send between its own bus cycles.
*/
`timescale 1ns/10ps
module crf_eng_model
(
   // clock
   input  wire logic              mclk,
   // decoded frames
   output logic                   rx_valid,
   output crf_pkg::crf_frame_type rx_frame
);
   initial
   begin
      rx_valid = 1'b0;
      rx_frame = '0;
   end

   // one-cycle strobe; lines inverted afterwards so stale data never matches
   task automatic send(input logic ext, input logic rtr, input logic [3:0] dlc,
                       input logic [28:0] id, input logic [63:0] dat);
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_frame <= {ext, rtr, dlc, id, dat};
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_frame <= ~{ext, rtr, dlc, id, dat};
      repeat (2) @(posedge mclk);
   endtask
endmodule

// *** sim/crf_rx_filter_monitor.sv ***
/*
 concurrent checks on the receive filter ports.
 assumes the master holds address and direction until ack.
*/
`timescale 1ns/10ps
module crf_rx_filter_monitor
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // watched ports
   input wire logic        rx_valid,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [9:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        rx_dropped
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   logic wr_seen;
   logic rd_fresh;
   // reset values only hold until software writes something
   always_ff @(posedge mclk)
      if (sys_rst)
         wr_seen <= 1'b0;
      else if (wb_ack_o && wb_we_i)
         wr_seen <= 1'b1;
   assign rd_fresh = wb_ack_o && !wb_we_i && !wr_seen;

   // ----------------------------------
   // bus timing and reset values
   // ----------------------------------
   sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence

   ack_latency_a: assert property (req_s |=> ack_s)
      else $error("ack not one cycle after request");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   code0_reset_a: assert property (rd_fresh && wb_adr_i[9:2] == 8'h10 |-> wb_dat_o[7:0] == 8'h51)
      else $error("code byte 0 reset value wrong");
   mask0_reset_a: assert property (rd_fresh && wb_adr_i[9:2] == 8'h14 |-> wb_dat_o[7:0] == 8'hff)
      else $error("mask byte 0 reset value wrong");
   drop_cause_a: assert property ($rose(rx_dropped) |-> $past(rx_valid) || $past(rx_valid, 2))
      else $error("drop flag without frame");
   reset_clear_a: assert property (disable iff (1'b0) sys_rst |=> !wb_ack_o && !rx_dropped)
      else $error("outputs active after reset");
endmodule

bind crf_rx_filter crf_rx_filter_monitor mon
(
   .mclk       (mclk),
   .sys_rst    (sys_rst),
   .rx_valid   (rx_valid),
   .wb_cyc_i   (wb_cyc_i),
   .wb_stb_i   (wb_stb_i),
   .wb_we_i    (wb_we_i),
   .wb_adr_i   (wb_adr_i),
   .wb_dat_o   (wb_dat_o),
   .wb_ack_o   (wb_ack_o),
   .rx_dropped (rx_dropped)
);

// *** sim/tb_top.sv ***
/*
 self-checking bench: register access, frame layout and filtering.
 assumes the engine model and the bound monitor are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
   logic                   mclk;
   logic                   sys_rst;
   logic                   rx_valid;
   crf_pkg::crf_frame_type rx_frame;
   logic                   wb_cyc_i;
   logic                   wb_stb_i;
   logic                   wb_we_i;
   logic [9:0]             wb_adr_i;
   logic [3:0]             wb_sel_i;
   logic [31:0]            wb_dat_i;
   logic [31:0]            wb_dat_o;
   logic                   wb_ack_o;
   logic                   rx_dropped;
   logic                   rx_overrun;
   logic [31:0]            rdat;
   int                     err_count = 0;
   int                     checks_done = 0;
   // dual filters: first on id bits 28..13 = 0x1122, second on id bits 28..13 = 0xb409
   logic [7:0]             cfg [8] = '{8'h11, 8'h22, 8'hb4, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00};

   crf_eng_model eng (.mclk(mclk), .rx_valid(rx_valid), .rx_frame(rx_frame));

   crf_rx_filter dut (.mclk(mclk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_frame(rx_frame),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .rx_dropped(rx_dropped), .rx_overrun(rx_overrun));

   initial
      mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   // ----------------------------------
   // access tasks
   // ----------------------------------
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, 4'h1, 24'h0, d};
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      rdat = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      if (wb_ack_o !== 1'b1)
      begin
         err_count++;
         summarize();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk(rdat, {24'h0, e});
   endtask

   initial
   begin
      sys_rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(8'h10, 8'h51);
      rd(8'h14, 8'hff);
      rd(8'h30, 8'h00);
      wr(8'h10, 8'hb4);
      wr(8'h14, 8'h00);
      wr(8'h11, 8'hff);
      wr(8'h15, 8'h00);
      rd(8'h11, 8'hff);
      wr(8'h00, 8'h00);
      // refused outside reset mode, else the next frame is lost
      wr(8'h10, 8'h00);
      eng.send(1'b0, 1'b0, 4'h8, 29'h5a3, 64'h1122334455667788);
      chk({31'h0, rx_dropped}, 32'h0);
      eng.send(1'b0, 1'b0, 4'h8, 29'h1a3, 64'h0);
      rd(8'h1d, 8'h01);
      chk({31'h0, rx_dropped}, 32'h1);
      rd(8'h10, 8'h08);
      rd(8'h11, 8'hb4);
      rd(8'h12, 8'h60);
      rd(8'h13, 8'h11);
      rd(8'h1a, 8'h88);
      wr(8'h20, 8'h00);
      rd(8'h1d, 8'h00);
      wr(8'h00, 8'h09);
      for (int i = 0; i < 8; i++)
         wr(8'(8'h10 + i), cfg[i]);
      wr(8'h00, 8'h08);
      eng.send(1'b1, 1'b0, 4'h8, 29'h16812345, 64'h0102030405060708);
      eng.send(1'b1, 1'b1, 4'h0, 29'h022440ff, 64'h0);
      eng.send(1'b1, 1'b0, 4'h8, 29'h0, 64'h0);
      rd(8'h1d, 8'h02);
      chk({31'h0, rx_dropped}, 32'h1);
      rd(8'h10, 8'h88);
      rd(8'h11, 8'hb4);
      rd(8'h12, 8'h09);
      rd(8'h13, 8'h1a);
      bus(1'b0, 8'h14, 8'h00);
      chk(rdat & 32'hfc, 32'h28);
      rd(8'h15, 8'h01);
      rd(8'h1c, 8'h08);
      wr(8'h20, 8'h00);
      rd(8'h10, 8'hc0);
      bus(1'b0, 8'h14, 8'h00);
      chk(rdat & 32'hfc, 32'hfc);
      chk({31'h0, rx_overrun}, 32'h0);
      // single full mode: unused code1 nibble must not block, data0 compared
      wr(8'h00, 8'h01);
      wr(8'h1f, 8'h80);
      wr(8'h10, 8'hb4);
      wr(8'h11, 8'h6f);
      wr(8'h12, 8'h11);
      wr(8'h13, 8'h22);
      wr(8'h00, 8'h00);
      eng.send(1'b0, 1'b0, 4'h2, 29'h5a3, 64'h1122000000000000);
      eng.send(1'b0, 1'b0, 4'h2, 29'h5a3, 64'h1022000000000000);
      rd(8'h1d, 8'h01);
      chk({31'h0, rx_dropped}, 32'h1);
      // single extended: rtr bit compared, two low bits unused
      wr(8'h00, 8'h01);
      wr(8'h11, 8'h09);
      wr(8'h12, 8'h1a);
      wr(8'h13, 8'h2b);
      wr(8'h00, 8'h00);
      eng.send(1'b1, 1'b0, 4'h0, 29'h16812345, 64'h0);
      eng.send(1'b1, 1'b1, 4'h0, 29'h16812345, 64'h0);
      rd(8'h1d, 8'h01);
      chk({31'h0, rx_dropped}, 32'h1);
      // dual base: filter 1 on id 0x5a3 and data0 0x3c, filter 2 on id 0x1a3 remote
      wr(8'h00, 8'h09);
      wr(8'h11, 8'h63);
      wr(8'h12, 8'h34);
      wr(8'h13, 8'h7c);
      wr(8'h00, 8'h08);
      eng.send(1'b0, 1'b0, 4'h1, 29'h5a3, 64'h3c00000000000000);
      eng.send(1'b0, 1'b1, 4'h0, 29'h1a3, 64'h0);
      eng.send(1'b0, 1'b0, 4'h1, 29'h5a3, 64'h3d00000000000000);
      eng.send(1'b0, 1'b0, 4'h0, 29'h1a3, 64'h0);
      rd(8'h1d, 8'h02);
      chk({31'h0, rx_dropped}, 32'h1);
      // fill the queue, one accepted frame beyond its depth
      for (int i = 0; i < 7; i++)
         eng.send(1'b0, 1'b0, 4'h1, 29'h5a3, 64'h3c00000000000000);
      rd(8'h1d, 8'h08);
      chk({31'h0, rx_overrun}, 32'h1);
      summarize();
   end
endmodule
